// ---- core/rcs_params.svh ----
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH

// clocks that outputs outlast the processor reset rising edge
`define RCS_CFG_HOLD_CLKS 2'h1
`define RCS_BREQ_HOLD_CLKS 2'h2
`define RCS_DELAYED_PROCESSOR_RESET_N_EXT_CLKS 2'h2
`define RCS_POST_LAST 2'h2
`define RCS_POST_ZERO 2'h0

// memory refresh after memory reset release
`define RCS_REFRESH_PER_BANK 8

// bridge clock ratio to host clock
`define RCS_PCI_DIV 3

// drive-config reset value: 4G vector, queue depth 8
`define RCS_DRIVE_CFG_RST 11'h030

`endif

// ---- core/rcs_pkg.sv ----
package rcs_pkg;

    // options sampled by every bus agent at reset
    typedef struct packed {
        logic parity_en;
        logic address_error_det_en;
        logic bus_error_det_en;
        logic bus_init_det_en;
        logic redundancy_check_mode;
        logic vector_4g;
        logic in_order_queue_deep;
        logic [1:0] cluster_id;
        logic [1:0] arb_id;
    } rcs_cfg_t;

    // reset outputs of the controller
    typedef struct packed {
        logic processor_reset_n;
        logic delayed_processor_reset_n;
        logic memory_reset_n;
        logic south_reset_n;
        logic config_reset_n;
        logic txn_reset_n;
        logic processor_init_n;
    } rcs_rst_t;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_HOLD,
        ST_RELEASE,
        ST_REFRESH,
        ST_READY
    } rcs_state_t;

endpackage

// ---- core/rcs_pci_clk_div.sv ----
`timescale 1ns/1ps
`include "rcs_params.svh"
module rcs_pci_clk_div
    import rcs_pkg::*;
#(
    parameter int DIV = `RCS_PCI_DIV
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // control
    input wire logic rephase_i,
    // clock out and feedback
    input wire logic pci_clk_fb_i,
    output logic pci_clk_o,
    output logic locked_o
);
    localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    localparam logic [CW-1:0] HIGH = CW'(DIV / 2);

    logic [CW-1:0] cnt_q, cnt_d;
    logic clk_q, clk_d;
    logic lock_q, lock_d;

    always_comb begin
        cnt_d = cnt_q;
        // re-phase: phase held at zero, clock held high meanwhile
        if (rephase_i) begin
            cnt_d = '0;
        end else if (cnt_q == LAST) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
        clk_d = (cnt_d < HIGH);
        // feedback aligned when it matches the internal tree each cycle
        lock_d = !rephase_i && (pci_clk_fb_i == clk_q);
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= '0;
            clk_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            clk_q <= clk_d;
            lock_q <= lock_d;
        end
    end

    assign pci_clk_o = clk_q;
    assign locked_o = lock_q;
endmodule

// ---- core/rcs_reset_seq.sv ----
`timescale 1ns/1ps
`include "rcs_params.svh"
module rcs_reset_seq
    import rcs_pkg::*;
#(
    parameter int RESET_HOLD = 16,
    parameter int SOFT_HOLD = 8,
    parameter int BRIDGE_HOLD = 16,
    parameter int BUS_INIT_N_HOLD = 4,
    parameter int NUM_BANKS = 4,
    parameter int NUM_BRIDGES = 2
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // power and reset requests
    input wire logic power_good_in_i,
    input wire logic hard_reset_req_i,
    input wire logic hard_reset_bist_i,
    input wire logic soft_reset_req_i,
    input wire logic bus_init_n_i,
    input wire logic [NUM_BRIDGES-1:0] bridge_reset_req_i,
    input wire logic [NUM_BRIDGES-1:0] rephase_en_i,
    // error flags
    input wire logic sticky_err_set_i,
    input wire logic sticky_err_clr_i,
    output logic sticky_err_o,
    // configuration registers and bus lines
    input wire logic drive_cfg_we_i,
    input wire rcs_cfg_t drive_cfg_wdata_i,
    input wire rcs_cfg_t cfg_bus_i,
    output rcs_cfg_t cfg_bus_o,
    output logic cfg_bus_oe_n_o,
    output rcs_cfg_t reset_drive_config_reg_o,
    output rcs_cfg_t reset_capture_config_reg_o,
    // resets
    output rcs_rst_t rst_o,
    output logic [NUM_BRIDGES-1:0] pci_reset_n_o,
    output logic power_good_buffered_out_o,
    // symmetric bus request
    output logic symmetric_bus_request_n_o,
    output logic symmetric_bus_request_oe_n_o,
    // status
    output logic boot_ready_o,
    output logic host_clk_phase_o,
    // memory refresh
    input wire logic refresh_ack_i,
    output logic refresh_req_o,
    output logic [$clog2(NUM_BANKS)-1:0] refresh_bank_o,
    // bridge clocks
    input wire logic [NUM_BRIDGES-1:0] pci_clk_fb_i,
    output logic [NUM_BRIDGES-1:0] pci_clk_o,
    output logic [NUM_BRIDGES-1:0] pci_locked_o
);
    localparam int RW = $clog2(RESET_HOLD + 1);
    localparam int SW = $clog2(SOFT_HOLD + 1);
    localparam int BW = $clog2(BRIDGE_HOLD + 1);
    localparam int IW = $clog2(BUS_INIT_N_HOLD + 1);
    localparam int PB = $clog2(`RCS_REFRESH_PER_BANK);
    localparam int KW = $clog2(NUM_BANKS) + PB;
    localparam int NB = $clog2(NUM_BANKS);
    localparam logic [RW-1:0] RST_LOAD = RW'(RESET_HOLD);
    localparam logic [SW-1:0] SOFT_LOAD = SW'(SOFT_HOLD);
    localparam logic [BW-1:0] BRG_LOAD = BW'(BRIDGE_HOLD);
    localparam logic [IW-1:0] BUS_INIT_N_LOAD = IW'(BUS_INIT_N_HOLD);
    localparam logic [KW-1:0] REF_LAST = KW'(NUM_BANKS * `RCS_REFRESH_PER_BANK - 1);
    localparam rcs_cfg_t DRIVE_RST = `RCS_DRIVE_CFG_RST;

    // sequencer state
    rcs_state_t state_q, state_d;
    logic [RW-1:0] rst_cnt_q, rst_cnt_d;
    logic [1:0] post_q, post_d;
    logic [KW-1:0] ref_cnt_q, ref_cnt_d;
    logic hard_q, hard_d;
    logic bist_q, bist_d;
    rcs_cfg_t cap_q, cap_d;
    rcs_cfg_t drv_q, drv_d;

    always_comb begin
        state_d = state_q;
        rst_cnt_d = rst_cnt_q;
        post_d = post_q;
        ref_cnt_d = ref_cnt_q;
        hard_d = hard_q;
        bist_d = bist_q;
        cap_d = cap_q;
        drv_d = drv_q;
        if (drive_cfg_we_i) begin
            drv_d = drive_cfg_wdata_i;
        end
        case (state_q)
            ST_OFF: begin
                if (power_good_in_i) begin
                    state_d = ST_HOLD;
                    rst_cnt_d = RST_LOAD;
                end
            end
            ST_HOLD: begin
                if (rst_cnt_q == '0) begin
                    state_d = ST_RELEASE;
                    post_d = `RCS_POST_ZERO;
                    // sampled on the same edge that lifts processor reset
                    cap_d = cfg_bus_i;
                end else begin
                    rst_cnt_d = rst_cnt_q - 1'b1;
                end
            end
            ST_RELEASE: begin
                if (post_q == `RCS_POST_LAST) begin
                    state_d = ST_REFRESH;
                    ref_cnt_d = '0;
                end else begin
                    post_d = post_q + 1'b1;
                end
            end
            ST_REFRESH: begin
                if (refresh_ack_i) begin
                    if (ref_cnt_q == REF_LAST) begin
                        state_d = ST_READY;
                    end else begin
                        ref_cnt_d = ref_cnt_q + 1'b1;
                    end
                end
            end
            ST_READY: begin
                state_d = ST_READY;
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
        // hard reset reruns the sequence but leaves drive config alone
        if (hard_reset_req_i && state_q == ST_READY) begin
            state_d = ST_HOLD;
            rst_cnt_d = RST_LOAD;
            hard_d = 1'b1;
            bist_d = hard_reset_bist_i;
        end
        if (!power_good_in_i) begin
            state_d = ST_OFF;
            hard_d = 1'b0;
            bist_d = 1'b0;
            drv_d = DRIVE_RST;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_OFF;
            rst_cnt_q <= '0;
            post_q <= `RCS_POST_ZERO;
            ref_cnt_q <= '0;
            hard_q <= 1'b0;
            bist_q <= 1'b0;
            cap_q <= DRIVE_RST;
            drv_q <= DRIVE_RST;
        end else begin
            state_q <= state_d;
            rst_cnt_q <= rst_cnt_d;
            post_q <= post_d;
            ref_cnt_q <= ref_cnt_d;
            hard_q <= hard_d;
            bist_q <= bist_d;
            cap_q <= cap_d;
            drv_q <= drv_d;
        end
    end

    // side resets: soft, bus-init and per bridge
    logic [SW-1:0] soft_cnt_q, soft_cnt_d;
    logic [IW-1:0] bus_init_n_cnt_q, bus_init_n_cnt_d;
    logic [NUM_BRIDGES-1:0][BW-1:0] brg_cnt_q, brg_cnt_d;
    logic sticky_q, sticky_d;
    logic in_reset_d;

    assign in_reset_d = (state_d == ST_OFF) || (state_d == ST_HOLD);

    always_comb begin
        soft_cnt_d = soft_cnt_q;
        bus_init_n_cnt_d = bus_init_n_cnt_q;
        brg_cnt_d = brg_cnt_q;
        sticky_d = sticky_q;
        if (in_reset_d) begin
            soft_cnt_d = '0;
        end else if (soft_reset_req_i) begin
            soft_cnt_d = SOFT_LOAD;
        end else if (soft_cnt_q != '0) begin
            soft_cnt_d = soft_cnt_q - 1'b1;
        end
        if (in_reset_d) begin
            bus_init_n_cnt_d = '0;
        end else if (!bus_init_n_i) begin
            bus_init_n_cnt_d = BUS_INIT_N_LOAD;
        end else if (bus_init_n_cnt_q != '0) begin
            bus_init_n_cnt_d = bus_init_n_cnt_q - 1'b1;
        end
        for (int i = 0; i < NUM_BRIDGES; i++) begin
            if (in_reset_d) begin
                brg_cnt_d[i] = '0;
            end else if (bridge_reset_req_i[i]) begin
                brg_cnt_d[i] = BRG_LOAD;
            end else if (brg_cnt_q[i] != '0) begin
                brg_cnt_d[i] = brg_cnt_q[i] - 1'b1;
            end
        end
        // power loss or a clear request clears sticky flags, hard reset does not; a new error beats a clear
        if (state_d == ST_OFF) begin
            sticky_d = 1'b0;
        end else if (sticky_err_set_i) begin
            sticky_d = 1'b1;
        end else if (sticky_err_clr_i) begin
            sticky_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            soft_cnt_q <= '0;
            bus_init_n_cnt_q <= '0;
            brg_cnt_q <= '0;
            sticky_q <= 1'b0;
        end else begin
            soft_cnt_q <= soft_cnt_d;
            bus_init_n_cnt_q <= bus_init_n_cnt_d;
            brg_cnt_q <= brg_cnt_d;
            sticky_q <= sticky_d;
        end
    end

    // registered outputs, computed from next state so edges are exact
    rcs_rst_t rst_q, rst_d;
    logic [NUM_BRIDGES-1:0] pci_rst_n_q, pci_rst_n_d;
    logic cfg_oe_n_q, cfg_oe_n_d;
    logic breq_oe_n_q, breq_oe_n_d;
    logic pgb_q, pgb_d;
    logic ready_q, ready_d;
    logic ref_req_q, ref_req_d;
    logic [NB-1:0] ref_bank_q, ref_bank_d;
    logic phase_q, phase_d;
    logic rel_d;

    assign rel_d = (state_d == ST_RELEASE);

    always_comb begin
        rst_d.processor_reset_n = !in_reset_d;
        rst_d.delayed_processor_reset_n =
            !(in_reset_d || (rel_d && post_d < `RCS_DELAYED_PROCESSOR_RESET_N_EXT_CLKS));
        rst_d.memory_reset_n = !in_reset_d;
        rst_d.south_reset_n = !in_reset_d;
        rst_d.config_reset_n = !in_reset_d;
        rst_d.txn_reset_n = !(in_reset_d || bus_init_n_cnt_d != '0);
        // quiet at power-up; self-test only through hard reset
        rst_d.processor_init_n =
            !((state_d == ST_HOLD && bist_d) || soft_cnt_d != '0);
        for (int i = 0; i < NUM_BRIDGES; i++) begin
            pci_rst_n_d[i] = !(in_reset_d || brg_cnt_d[i] != '0);
        end
        cfg_oe_n_d = !(in_reset_d || (rel_d && post_d < `RCS_CFG_HOLD_CLKS));
        breq_oe_n_d = !(in_reset_d || (rel_d && post_d < `RCS_BREQ_HOLD_CLKS));
        pgb_d = power_good_in_i && !(hard_d && in_reset_d);
        ready_d = (state_d == ST_READY);
        ref_req_d = (state_d == ST_REFRESH);
        ref_bank_d = ref_cnt_d[KW-1:PB];
        phase_d = !phase_q;
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_q <= '0;
            pci_rst_n_q <= '0;
            cfg_oe_n_q <= 1'b0;
            breq_oe_n_q <= 1'b0;
            pgb_q <= 1'b0;
            ready_q <= 1'b0;
            ref_req_q <= 1'b0;
            ref_bank_q <= '0;
            phase_q <= 1'b0;
        end else begin
            rst_q <= rst_d;
            pci_rst_n_q <= pci_rst_n_d;
            cfg_oe_n_q <= cfg_oe_n_d;
            breq_oe_n_q <= breq_oe_n_d;
            pgb_q <= pgb_d;
            ready_q <= ready_d;
            ref_req_q <= ref_req_d;
            ref_bank_q <= ref_bank_d;
            phase_q <= phase_d;
        end
    end

    // bridge clocks restart in phase with any reset except another bridge's, unless defeated
    logic any_rst_q;
    assign any_rst_q = !rst_q.processor_reset_n || soft_cnt_q != '0 || bus_init_n_cnt_q != '0;

    for (genvar g = 0; g < NUM_BRIDGES; g++) begin : g_div
        rcs_pci_clk_div #(
            .DIV(`RCS_PCI_DIV)
        ) u_div (
            .sys_clk_i(sys_clk_i),
            .resetn_i(resetn_i),
            .rephase_i(rephase_en_i[g] && (any_rst_q || !pci_rst_n_q[g])),
            .pci_clk_fb_i(pci_clk_fb_i[g]),
            .pci_clk_o(pci_clk_o[g]),
            .locked_o(pci_locked_o[g])
        );
    end

    assign cfg_bus_o = drv_q;
    assign cfg_bus_oe_n_o = cfg_oe_n_q;
    assign reset_drive_config_reg_o = drv_q;
    assign reset_capture_config_reg_o = cap_q;
    assign rst_o = rst_q;
    assign pci_reset_n_o = pci_rst_n_q;
    assign power_good_buffered_out_o = pgb_q;
    assign symmetric_bus_request_n_o = 1'b0;
    assign symmetric_bus_request_oe_n_o = breq_oe_n_q;
    assign sticky_err_o = sticky_q;
    assign boot_ready_o = ready_q;
    assign host_clk_phase_o = phase_q;
    assign refresh_req_o = ref_req_q;
    assign refresh_bank_o = ref_bank_q;
endmodule

// ---- bench/rcs_reset_seq_monitor.sv ----
`timescale 1ns/1ps
module rcs_reset_seq_monitor
    import rcs_pkg::*;
#(
    parameter int NUM_BANKS = 4,
    parameter int NUM_BRIDGES = 2
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // requests
    input wire logic power_good_in_i,
    input wire logic hard_reset_req_i,
    input wire logic hard_reset_bist_i,
    input wire logic soft_reset_req_i,
    input wire logic bus_init_n_i,
    input wire logic [NUM_BRIDGES-1:0] bridge_reset_req_i,
    input wire logic refresh_ack_i,
    input wire rcs_cfg_t cfg_bus_i,
    // outputs
    input wire rcs_cfg_t cfg_bus_o,
    input wire logic cfg_bus_oe_n_o,
    input wire rcs_cfg_t reset_drive_config_reg_o,
    input wire rcs_cfg_t reset_capture_config_reg_o,
    input wire rcs_rst_t rst_o,
    input wire logic [NUM_BRIDGES-1:0] pci_reset_n_o,
    input wire logic power_good_buffered_out_o,
    input wire logic symmetric_bus_request_oe_n_o,
    input wire logic boot_ready_o,
    input wire logic refresh_req_o,
    input wire logic [$clog2(NUM_BANKS)-1:0] refresh_bank_o,
    input wire logic [NUM_BRIDGES-1:0] pci_clk_o
);
    localparam int ALL_ACKS = 8 * NUM_BANKS;
    logic [7:0] acks_q;
    logic [7:0] acks_d;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    always_comb begin
        acks_d = acks_q;
        if (!rst_o.memory_reset_n) begin
            acks_d = 8'h00;
        end else if (refresh_req_o && refresh_ack_i) begin
            acks_d = acks_q + 8'h01;
        end
    end
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acks_q <= 8'h00;
        end else begin
            acks_q <= acks_d;
        end
    end
    sequence s_cpu_rise;
        $rose(rst_o.processor_reset_n);
    endsequence
    sequence s_low2_high(x);
        !x [*2] ##1 x;
    endsequence
    property p_pg_off;
        !power_good_in_i [*4] |-> !rst_o.processor_reset_n && !rst_o.memory_reset_n
            && pci_reset_n_o == '0 && !power_good_buffered_out_o;
    endproperty
    a_pg_off: assert property (p_pg_off) else $error("resets not held with power low");
    property p_drive;
        !rst_o.processor_reset_n |-> !cfg_bus_oe_n_o && cfg_bus_o == reset_drive_config_reg_o;
    endproperty
    a_drive: assert property (p_drive) else $error("bus not showing drive config");
    property p_cfg_hold;
        s_cpu_rise |-> !cfg_bus_oe_n_o ##1 cfg_bus_oe_n_o;
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config drive hold wrong");
    property p_capture;
        s_cpu_rise |-> reset_capture_config_reg_o == $past(cfg_bus_i);
    endproperty
    a_capture: assert property (p_capture) else $error("capture register wrong");
    property p_breq;
        s_cpu_rise |-> s_low2_high(symmetric_bus_request_oe_n_o);
    endproperty
    a_breq: assert property (p_breq) else $error("symmetric request hold wrong");
    property p_delayed;
        s_cpu_rise |-> s_low2_high(rst_o.delayed_processor_reset_n);
    endproperty
    a_delayed: assert property (p_delayed) else $error("delayed reset wrong");
    property p_refresh_start;
        $rose(rst_o.memory_reset_n) |-> !refresh_req_o ##3 refresh_req_o && refresh_bank_o == '0;
    endproperty
    a_refresh_start: assert property (p_refresh_start) else $error("refresh start wrong");
    property p_refresh_count;
        $fell(refresh_req_o) && rst_o.processor_reset_n |-> acks_q == 8'(ALL_ACKS) && boot_ready_o;
    endproperty
    a_refresh_count: assert property (p_refresh_count) else $error("refresh count wrong");
    property p_bank;
        refresh_req_o |-> refresh_bank_o == acks_q[3 +: $clog2(NUM_BANKS)];
    endproperty
    a_bank: assert property (p_bank) else $error("refresh bank wrong");
    property p_pgb_copy;
        boot_ready_o && $past(boot_ready_o) |-> power_good_buffered_out_o == $past(power_good_in_i);
    endproperty
    a_pgb_copy: assert property (p_pgb_copy) else $error("buffered power good wrong");
    property p_hard;
        hard_reset_req_i && boot_ready_o |=> !power_good_buffered_out_o && !rst_o.processor_reset_n
            && rst_o.processor_init_n == !$past(hard_reset_bist_i) && $stable(reset_drive_config_reg_o);
    endproperty
    a_hard: assert property (p_hard) else $error("hard reset entry wrong");
    property p_soft;
        soft_reset_req_i && boot_ready_o |=> !rst_o.processor_init_n && rst_o.memory_reset_n
            && rst_o.config_reset_n && pci_reset_n_o == '1;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset wrong");
    property p_bus_init_n;
        !bus_init_n_i && boot_ready_o |=> !rst_o.txn_reset_n && rst_o.memory_reset_n
            && rst_o.config_reset_n;
    endproperty
    a_bus_init_n: assert property (p_bus_init_n) else $error("bus init reset wrong");
    property p_bridge;
        boot_ready_o && $onehot(bridge_reset_req_i) |=> pci_reset_n_o == ~$past(bridge_reset_req_i)
            && rst_o.processor_reset_n;
    endproperty
    a_bridge: assert property (p_bridge) else $error("bridge reset wrong");
    property p_pci_div;
        (rst_o == '1 && pci_reset_n_o == '1 && boot_ready_o) [*6] |-> pci_clk_o == $past(pci_clk_o, 3);
    endproperty
    a_pci_div: assert property (p_pci_div) else $error("bridge clock period wrong");
endmodule

bind rcs_reset_seq rcs_reset_seq_monitor #(
    .NUM_BANKS(NUM_BANKS),
    .NUM_BRIDGES(NUM_BRIDGES)
) i_mon (
    .sys_clk_i, .resetn_i, .power_good_in_i, .hard_reset_req_i, .hard_reset_bist_i,
    .soft_reset_req_i, .bus_init_n_i, .bridge_reset_req_i, .refresh_ack_i, .cfg_bus_i,
    .cfg_bus_o, .cfg_bus_oe_n_o, .reset_drive_config_reg_o, .reset_capture_config_reg_o,
    .rst_o, .pci_reset_n_o, .power_good_buffered_out_o, .symmetric_bus_request_oe_n_o,
    .boot_ready_o, .refresh_req_o, .refresh_bank_o, .pci_clk_o
);

// ---- bench/rcs_bus_agent.sv ----
`timescale 1ns/1ps
module rcs_bus_agent
    import rcs_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // controller side
    input wire rcs_cfg_t drv_i,
    input wire logic drv_oe_n_i,
    input wire logic cpu_rst_n_i,
    input wire logic refresh_req_i,
    // scenario controls
    input wire logic ovr_en_i,
    input wire rcs_cfg_t ovr_i,
    input wire logic slow_i,
    // wire and answers
    output rcs_cfg_t bus_o,
    output rcs_cfg_t latched_o,
    output logic refresh_ack_o
);
    rcs_cfg_t last_q;
    logic prev_q;
    logic tog_q;
    // strong external strap wins; a released line toggles each cycle, first to the inverse of its old value, then back to it
    assign bus_o = ovr_en_i ? ovr_i : (!drv_oe_n_i ? drv_i : ~last_q);
    assign refresh_ack_o = refresh_req_i && (!slow_i || tog_q);
    // no priority requests issued, so depth one cannot starve the bus
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            last_q <= '0;
            prev_q <= 1'b0;
            tog_q <= 1'b0;
            latched_o <= '0;
        end else begin
            last_q <= bus_o;
            prev_q <= cpu_rst_n_i;
            tog_q <= !tog_q;
            if (cpu_rst_n_i && !prev_q) begin
                latched_o <= bus_o;
            end
        end
    end
endmodule

// ---- bench/rcs_reset_seq_tb_top.sv ----
`timescale 1ns/1ps
module rcs_reset_seq_tb_top
    import rcs_pkg::*;
;
    localparam int HOLD = 2;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic pg = 1'b0, hard = 1'b0, bist = 1'b0, soft_req = 1'b0, bus_init_n_n = 1'b1, we = 1'b0;
    logic set = 1'b0, clr = 1'b0, ovr_en = 1'b0, slow = 1'b0, ack, oe_n, sticky, pgb;
    logic breq, breq_oe_n, ready, phase, req;
    logic [1:0] brq = 2'h0, reph = 2'h0, rst_n, pclk, lock, bank;
    rcs_cfg_t wdata = 11'h000, ovr = 11'h000, bus_in, bus_out, drv, cap, seen;
    rcs_rst_t rst;
    logic [31:0] seed = 32'h0000_002f;
    int fails = 0, check_count = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    rcs_reset_seq #(.RESET_HOLD(HOLD), .SOFT_HOLD(HOLD), .BRIDGE_HOLD(6), .BUS_INIT_N_HOLD(HOLD)) i_dut (
        .sys_clk_i, .resetn_i, .power_good_in_i(pg), .hard_reset_req_i(hard),
        .hard_reset_bist_i(bist), .soft_reset_req_i(soft_req), .bus_init_n_i(bus_init_n_n),
        .bridge_reset_req_i(brq), .rephase_en_i(reph), .sticky_err_set_i(set),
        .sticky_err_clr_i(clr), .sticky_err_o(sticky), .drive_cfg_we_i(we),
        .drive_cfg_wdata_i(wdata), .cfg_bus_i(bus_in), .cfg_bus_o(bus_out),
        .cfg_bus_oe_n_o(oe_n), .reset_drive_config_reg_o(drv),
        .reset_capture_config_reg_o(cap), .rst_o(rst), .pci_reset_n_o(rst_n),
        .power_good_buffered_out_o(pgb), .symmetric_bus_request_n_o(breq),
        .symmetric_bus_request_oe_n_o(breq_oe_n), .boot_ready_o(ready),
        .host_clk_phase_o(phase), .refresh_ack_i(ack), .refresh_req_o(req),
        .refresh_bank_o(bank), .pci_clk_fb_i(pclk), .pci_clk_o(pclk), .pci_locked_o(lock));
    rcs_bus_agent i_agent (.sys_clk_i, .resetn_i, .drv_i(bus_out), .drv_oe_n_i(oe_n),
        .cpu_rst_n_i(rst.processor_reset_n), .refresh_req_i(req), .ovr_en_i(ovr_en),
        .ovr_i(ovr), .slow_i(slow), .bus_o(bus_in), .latched_o(seen), .refresh_ack_o(ack));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // an external strap beats the driven defaults
    function automatic rcs_cfg_t exp_cfg(logic en, rcs_cfg_t o, rcs_cfg_t d);
        return en ? o : d;
    endfunction
    task automatic chk(string name, logic [31:0] got, logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk_i);
        #2;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        chk("boot_ready", ready, 1);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        fails++;
        test_done();
    end
    initial begin
        int ones;
        tick(2);
        resetn_i = 1'b1;
        tick(2);
        chk("cpu_rst", rst.processor_reset_n, 0);
        chk("pci_rst", rst_n, 0);
        chk("drive_dflt", drv, 11'h030);
        pg = 1'b1;
        tick(2);
        chk("bus_drive", bus_out, 11'h030);
        wait_ready();
        chk("capture", cap, 11'h030);
        chk("agent", seen, 11'h030);
        chk("init_quiet", rst.processor_init_n, 1);
        chk("pgb", pgb, 1);
        chk("pci_lock", lock, 2'h3);
        chk("breq_low", breq, 0);
        ones = phase;
        tick(1);
        chk("host_phase", phase, !ones[0]);
        pulse(set);
        chk("sticky", sticky, 1);
        for (int i = 0; i < 5; i++) begin
            wdata = 11'(rnd());
            ovr = 11'(rnd());
            {ovr_en, slow, bist} = 3'(rnd());
            if (i < 2) begin
                wdata = i ? 11'h000 : 11'h7ff;
            end
            pulse(we);
            hard = 1'b1;
            tick(1);
            hard = 1'b0;
            chk("pgb_hard", pgb, 0);
            chk("init_bist", rst.processor_init_n, !bist);
            chk("cpu_hard", rst.processor_reset_n, 0);
            wait_ready();
            chk("drive_kept", drv, wdata);
            chk("capture", cap, exp_cfg(ovr_en, ovr, wdata));
            chk("agent", seen, exp_cfg(ovr_en, ovr, wdata));
            chk("sticky_kept", sticky, 1);
            ovr_en = 1'b0;
        end
        // a fresh error in the clearing cycle must survive
        set = 1'b1;
        pulse(clr);
        set = 1'b0;
        chk("sticky_both", sticky, 1);
        pulse(clr);
        chk("sticky_clr", sticky, 0);
        pulse(soft_req);
        chk("soft_init", rst.processor_init_n, 0);
        chk("soft_keep", {rst.memory_reset_n, rst.config_reset_n, rst_n}, 4'hf);
        tick(HOLD + 1);
        chk("soft_end", rst.processor_init_n, 1);
        bus_init_n_n = 1'b0;
        tick(1);
        bus_init_n_n = 1'b1;
        chk("bus_init_n_txn", rst.txn_reset_n, 0);
        chk("bus_init_n_keep", {rst.memory_reset_n, rst.config_reset_n}, 2'h3);
        tick(8);
        chk("bus_init_n_cfg", drv, wdata);
        reph = 2'h1;
        for (int i = 0; i < 2; i++) begin
            brq[i] = 1'b1;
            tick(1);
            brq = 2'h0;
            chk("bridge_rst", rst_n, 2'(~(2'h1 << i)));
            chk("bridge_cpu", rst.processor_reset_n, 1);
            tick(3);
            ones = 0;
            for (int k = 0; k < 3; k++) begin
                ones += pclk[i];
                tick(1);
            end
            chk("pci_clk", ones, reph[i] ? 3 : 1);
            chk("pci_lock", lock[i], !reph[i]);
            tick(8);
        end
        pg = 1'b0;
        tick(4);
        chk("pg_cpu", rst.processor_reset_n, 0);
        chk("pg_pci", rst_n, 0);
        chk("pgb_off", pgb, 0);
        pg = 1'b1;
        wait_ready();
        chk("drive_reinit", drv, 11'h030);
        chk("capture_pg", cap, 11'h030);
        resetn_i = 1'b0;
        tick(2);
        resetn_i = 1'b1;
        wait_ready();
        test_done();
    end
endmodule
